/* rtl/capture_pkg.sv */
/*
 * Shared constants, register map and carrier types of the two-channel
 * triggered capture controller.
 * Assumes a byte-wide register address whose top bit selects the channel.
 */
package capture_pkg;
    localparam int NCH        = 2;
    localparam int ADDR_W     = 20;
    localparam int DATA_W     = 24;
    localparam int LEVEL_W    = 16;
    localparam int FIFO_DEPTH = 16;

    // register offsets within one channel; bit 7 of the address picks the channel
    localparam logic [6:0] OFS_LEVEL  = 7'h00;
    localparam logic [6:0] OFS_ADDR   = 7'h01;
    localparam logic [6:0] OFS_DATA   = 7'h02;
    localparam logic [6:0] OFS_CAPDIV = 7'h03;
    localparam logic [6:0] OFS_SRC    = 7'h04;
    localparam logic [6:0] OFS_MODE   = 7'h05;
    localparam logic [6:0] OFS_CLKDIV = 7'h06;
    localparam logic [6:0] OFS_WRAP   = 7'h08;
    localparam logic [6:0] OFS_LOCK   = 7'h0F;
    localparam int         CH_SEL_BIT = 7;

    localparam logic [7:0] SRC_FRONT  = 8'h00;
    localparam logic [7:0] SRC_BP0    = 8'h01;
    localparam logic [7:0] SRC_BP7    = 8'h08;
    localparam logic [7:0] SRC_STAR   = 8'h09;
    localparam logic [7:0] SRC_SW_LO  = 8'h10;
    localparam logic [7:0] SRC_SW_HI  = 8'h11;
    localparam logic [7:0] SRC_ANALOG = 8'h12;
    localparam logic [7:0] SRC_RESET  = 8'h00;

    localparam logic [7:0] MODE_POS_LEVEL = 8'h00;
    localparam logic [7:0] MODE_NEG_LEVEL = 8'h01;
    localparam logic [7:0] MODE_POS_EDGE  = 8'h02;
    localparam logic [7:0] MODE_NEG_EDGE  = 8'h03;
    localparam logic [7:0] MODE_CONT_POS  = 8'h04;
    localparam logic [7:0] MODE_CONT_NEG  = 8'h05;

    localparam int               CLKDIV_HALF_BIT = 4;
    localparam logic [ADDR_W-1:0] ADDR_LAST  = 20'hFFFFF;
    localparam logic [ADDR_W-1:0] ADDR_FIRST = 20'h00000;
    localparam logic [ADDR_W-1:0] ADDR_ONE   = 20'h00001;
    localparam logic [3:0]        NIBBLE_ZERO = 4'h0;

    typedef enum logic [1:0] {
        CAP_IDLE  = 2'b00,
        CAP_ARMED = 2'b01,
        CAP_RUN   = 2'b11,
        CAP_DONE  = 2'b10
    } cap_state_e;

    typedef struct packed {
        logic [7:0]         addr;
        logic [DATA_W-1:0]  wdata;
        logic               wr;
        logic               rd;
    } host_req_s;

    typedef struct packed {
        logic               front;
        logic [7:0]         bp;
        logic               star;
    } trig_in_s;

    typedef struct packed {
        logic [ADDR_W-1:0]  addr;
        logic [DATA_W-1:0]  data;
    } stored_word_s;

    typedef struct packed {
        logic               lock;
        logic               wrap;
        logic               overflow;
        logic [LEVEL_W-1:0] level;
        logic [3:0]         capdiv;
        logic [3:0]         divcnt;
        logic [7:0]         src;
        logic [7:0]         mode;
        logic [ADDR_W-1:0]  addr;
        logic               prev_active;
        cap_state_e         state;
    } chan_s;
endpackage : capture_pkg

/* rtl/capture_ctrl.sv */
/*
 * Two-channel triggered capture controller: register file, trigger
 * circuits, address counters, sample FIFOs and the capture memories.
 * Assumes host strobes, trigger pins and the sample tick are synchronous
 * to clk_sys_i and that each strobe lasts one cycle.
 */
// Behaviour
// RULE1 - capture responds to triggers only after lock is written as one
// RULE2 - each channel has its own trigger source, mode and circuit
// RULE3 - front input, backplane lines 0-7 and star line are selectable sources
// RULE4 - hardware sources offer positive/negative level and edge; software has none
// RULE5 - level mode captures while the trigger stays active
// RULE6 - normal edge mode starts on one edge and stops on the next
// RULE7 - continuous edge mode runs until the host unlocks the channel
// RULE8 - unlocking stops capture and clears the trigger register
// RULE9 - with software source, writing the trigger register starts or stops capture
// RULE10 - each channel owns a 1M x 24-bit memory behind one address counter
// RULE11 - host loads the start address before arming
// RULE12 - counter climbs from start address on sample ticks during capture
// RULE13 - at last address stop, or wrap to zero when wrap is set
// RULE14 - in bus access mode every memory access advances the counter
// RULE15 - memory is closed to the host while locked; unlock aborts capture
// RULE16 - 16-bit level value compared against upper ADC sample bits
// RULE17 - address counter register is readable and writable, 20 bits
// RULE18 - data register accesses the current address and auto-increments
// RULE19 - write-only 4-bit capture divider spaces stored samples
// RULE20 - source codes: 0 front, 1-8 backplane, 9 star, 16/17 software
// RULE21 - mode codes 0-5 for level, edge and continuous edge polarities
// RULE22 - one shared 4-bit clock divider reachable from both channels
// RULE23 - divider value sixteen adds a divide-by-two 50 percent stage
// RULE24 - lock register: one locks and arms, zero returns to bus access
// RULE25 - wrap enable is one bit in its own register
// RULE26 - second channel registers sit at first channel offsets plus 80 hex
// RULE27 - unlisted source codes never trigger; code 12 hex (SRC_ANALOG) triggers on the ADC level compare
// RULE28 - counter advances only for samples the divider keeps
`timescale 1ns/10ps
`default_nettype none

module sample_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic             ce_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = AW'(0) + (AW+1)'(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0]   count;
    } fifo_s;

    fifo_s            st;
    fifo_s            next_st;
    logic [WIDTH-1:0] store [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready_o  = (st.count != FULL);
    assign out_valid_o = (st.count != '0);
    assign out_data_o  = store[st.rptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wptr = st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = st.rptr + 1'b1;
        end
        next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (ce_i && push) begin
            store[st.wptr] <= in_data_i;
        end
    end
endmodule : sample_fifo

module capture_ctrl (
    input  wire logic                                          clk_sys_i,
    input  wire logic                                          rst_i,
    input  wire logic                                          ce_i,
    input  wire capture_pkg::host_req_s                        host_i,
    output logic [capture_pkg::DATA_W-1:0]                     rdata_o,
    output logic                                               rvalid_o,
    input  wire logic                                          sample_tick_i,
    input  wire logic [capture_pkg::NCH-1:0][capture_pkg::DATA_W-1:0] adc_i,
    input  wire capture_pkg::trig_in_s                         trig_i,
    output logic                                               mclk_o
);
    import capture_pkg::*;

    typedef struct packed {
        chan_s [NCH-1:0]   ch;
        logic [7:0]        clkdiv;
        logic [3:0]        mcnt;
        logic              mclk;
        logic [DATA_W-1:0] rdata;
        logic              rvalid;
    } top_s;

    top_s                st;
    top_s                next_st;
    logic [DATA_W-1:0]   mem [NCH][2**ADDR_W];
    logic [NCH-1:0]      push;
    logic [NCH-1:0]      fifo_in_ready;
    logic [NCH-1:0]      fifo_out_valid;
    logic [NCH-1:0]      fifo_out_ready;
    stored_word_s [NCH-1:0] fifo_in;
    stored_word_s [NCH-1:0] fifo_out;
    logic [NCH-1:0]      host_mem_wr;
    logic [NCH-1:0]      host_mem_rd;
    logic [NCH-1:0]      usable;
    logic [NCH-1:0]      active;
    logic [NCH-1:0]      edge_hit;
    logic [NCH-1:0]      sw_hit;
    logic [NCH-1:0]      lvl_mode;
    logic [NCH-1:0]      cont_mode;
    logic [NCH-1:0]      unlock_wr;
    logic [NCH-1:0]      end_stop;

    function automatic logic reg_hit(host_req_s h, int unsigned ch, logic [6:0] ofs);
        return (h.addr[CH_SEL_BIT] == ch[0]) && (h.addr[6:0] == ofs);
    endfunction : reg_hit

    function automatic logic is_sw(logic [7:0] src);
        return (src == SRC_SW_LO) || (src == SRC_SW_HI);
    endfunction : is_sw

    // returns {usable, raw level}; reserved codes are never usable
    function automatic logic [1:0] trig_pick(logic [7:0] src, trig_in_s t, logic analog);
        logic [7:0] idx;
        idx = src - SRC_BP0;
        if (src == SRC_FRONT) begin                                 // RULE3
            return {1'b1, t.front};
        end else if (src >= SRC_BP0 && src <= SRC_BP7) begin        // RULE20
            return {1'b1, t.bp[idx[2:0]]};
        end else if (src == SRC_STAR) begin
            return {1'b1, t.star};
        end else if (src == SRC_ANALOG) begin
            return {1'b1, analog};
        end else begin
            return 2'b00;                                           // RULE27
        end
    endfunction : trig_pick

    always_comb begin                                               // RULE2
        logic [1:0] sel;
        logic       analog;
        logic       neg;
        sel    = 2'b00;
        analog = 1'b0;
        neg    = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            analog  = (adc_i[c][DATA_W-1:DATA_W-LEVEL_W] >= st.ch[c].level); // RULE16
            sel     = trig_pick(st.ch[c].src, trig_i, analog);
            neg     = (st.ch[c].mode == MODE_NEG_LEVEL) || (st.ch[c].mode == MODE_NEG_EDGE)
                      || (st.ch[c].mode == MODE_CONT_NEG);          // RULE4
            usable[c]    = sel[1] && (st.ch[c].mode <= MODE_CONT_NEG); // RULE21
            active[c]    = sel[0] ^ neg;
            edge_hit[c]  = usable[c] && active[c] && !st.ch[c].prev_active;
            lvl_mode[c]  = (st.ch[c].mode == MODE_POS_LEVEL) || (st.ch[c].mode == MODE_NEG_LEVEL);
            cont_mode[c] = (st.ch[c].mode == MODE_CONT_POS) || (st.ch[c].mode == MODE_CONT_NEG);
            sw_hit[c]    = host_i.wr && reg_hit(host_i, c, OFS_SRC) && is_sw(host_i.wdata[7:0]);
            unlock_wr[c] = host_i.wr && reg_hit(host_i, c, OFS_LOCK) && !host_i.wdata[0];
            host_mem_wr[c] = host_i.wr && reg_hit(host_i, c, OFS_DATA) && !st.ch[c].lock;
            host_mem_rd[c] = host_i.rd && reg_hit(host_i, c, OFS_DATA) && !st.ch[c].lock;
            push[c]      = (st.ch[c].state == CAP_RUN) && sample_tick_i
                           && (st.ch[c].divcnt == NIBBLE_ZERO);     // RULE28
            fifo_in[c]   = '{addr: st.ch[c].addr, data: adc_i[c]};
            end_stop[c]  = push[c] && fifo_in_ready[c] && (st.ch[c].addr == ADDR_LAST)
                           && !st.ch[c].wrap;
        end
    end

    always_comb begin
        next_st        = st;
        next_st.rvalid = 1'b0;
        for (int c = 0; c < NCH; c++) begin
            next_st.ch[c].prev_active = usable[c] && active[c];
            // capture sequencing
            case (st.ch[c].state)
                CAP_ARMED: begin
                    if (is_sw(st.ch[c].src)) begin
                        if (sw_hit[c]) begin                        // RULE9
                            next_st.ch[c].state = CAP_RUN;
                        end
                    end else if (lvl_mode[c] ? (usable[c] && active[c]) : edge_hit[c]) begin
                        next_st.ch[c].state = CAP_RUN;              // RULE1
                    end
                    next_st.ch[c].divcnt = NIBBLE_ZERO;
                end
                CAP_RUN: begin
                    if (is_sw(st.ch[c].src)) begin
                        if (sw_hit[c]) begin                        // RULE9
                            next_st.ch[c].state = CAP_DONE;
                        end
                    end else if (lvl_mode[c]) begin
                        if (!(usable[c] && active[c])) begin        // RULE5
                            next_st.ch[c].state = CAP_DONE;
                        end
                    end else if (!cont_mode[c] && edge_hit[c]) begin // RULE6
                        next_st.ch[c].state = CAP_DONE;
                    end                                             // RULE7
                end
                CAP_IDLE, CAP_DONE: begin
                end
                default: begin
                    next_st.ch[c].state = CAP_IDLE;
                end
            endcase
            // address counter during capture
            if (push[c]) begin
                next_st.ch[c].divcnt = st.ch[c].capdiv;             // RULE19
                if (!fifo_in_ready[c]) begin
                    next_st.ch[c].overflow = 1'b1;
                end else if (st.ch[c].addr == ADDR_LAST) begin
                    if (st.ch[c].wrap) begin                        // RULE13
                        next_st.ch[c].addr = ADDR_FIRST;
                    end else begin
                        next_st.ch[c].state = CAP_DONE;
                    end
                end else begin
                    next_st.ch[c].addr = st.ch[c].addr + ADDR_ONE;  // RULE12
                end
            end else if (st.ch[c].state == CAP_RUN && sample_tick_i) begin
                next_st.ch[c].divcnt = st.ch[c].divcnt - 4'h1;
            end
            // bus access mode: each memory access steps the counter
            if (host_mem_wr[c] || host_mem_rd[c]) begin            // RULE14
                next_st.ch[c].addr = st.ch[c].addr + ADDR_ONE;      // RULE18
            end
            if (host_i.wr) begin
                if (reg_hit(host_i, c, OFS_LEVEL)) begin
                    next_st.ch[c].level = host_i.wdata[LEVEL_W-1:0];
                end
                if (reg_hit(host_i, c, OFS_ADDR) && !st.ch[c].lock) begin
                    next_st.ch[c].addr = host_i.wdata[ADDR_W-1:0];  // RULE17
                end
                if (reg_hit(host_i, c, OFS_CAPDIV)) begin
                    next_st.ch[c].capdiv = host_i.wdata[3:0];
                end
                if (reg_hit(host_i, c, OFS_SRC)) begin
                    next_st.ch[c].src = host_i.wdata[7:0];
                end
                if (reg_hit(host_i, c, OFS_MODE)) begin
                    next_st.ch[c].mode = host_i.wdata[7:0];
                end
                if (reg_hit(host_i, c, OFS_WRAP)) begin             // RULE25
                    next_st.ch[c].wrap = host_i.wdata[0];
                end
                if (reg_hit(host_i, c, OFS_LOCK)) begin             // RULE24
                    next_st.ch[c].lock     = host_i.wdata[0];
                    next_st.ch[c].overflow = push[c] && !fifo_in_ready[c];
                    if (host_i.wdata[0]) begin
                        next_st.ch[c].state = CAP_ARMED;
                    end else begin
                        next_st.ch[c].state = CAP_IDLE;             // RULE15
                        next_st.ch[c].src   = SRC_RESET;            // RULE8
                        next_st.ch[c].addr  = st.ch[c].addr;
                    end
                end
            end
        end
        // shared divider, same storage for both channel windows
        if (host_i.wr && host_i.addr[6:0] == OFS_CLKDIV) begin     // RULE22
            next_st.clkdiv = host_i.wdata[7:0];
        end
        if (st.mcnt == st.clkdiv[3:0]) begin
            next_st.mcnt = NIBBLE_ZERO;
            next_st.mclk = st.clkdiv[CLKDIV_HALF_BIT] ? !st.mclk : 1'b1; // RULE23
        end else begin
            next_st.mcnt = st.mcnt + 4'h1;
            next_st.mclk = st.clkdiv[CLKDIV_HALF_BIT] ? st.mclk : 1'b0;
        end
        // read answer, one cycle after the strobe
        if (host_i.rd) begin                                        // RULE26
            next_st.rvalid = 1'b1;
            next_st.rdata  = '0;
            for (int c = 0; c < NCH; c++) begin
                if (reg_hit(host_i, c, OFS_ADDR)) begin
                    next_st.rdata = DATA_W'(st.ch[c].addr);
                end
                if (host_mem_rd[c]) begin                           // RULE15
                    next_st.rdata = mem[c][st.ch[c].addr];
                end
                if (reg_hit(host_i, c, OFS_LOCK)) begin
                    next_st.rdata = DATA_W'({st.ch[c].state, st.ch[c].overflow, st.ch[c].lock});
                end
            end
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // a host access to the memory takes the port; the drain waits a cycle
    generate
        for (genvar g = 0; g < NCH; g++) begin : g_chan
            assign fifo_out_ready[g] = !(host_mem_wr[g] || host_mem_rd[g]);
            sample_fifo #(
                .WIDTH ($bits(stored_word_s)),
                .DEPTH (FIFO_DEPTH)
            ) u_fifo (
                .clk_sys_i   (clk_sys_i),
                .rst_i       (rst_i),
                .ce_i        (ce_i),
                .in_valid_i  (push[g]),
                .in_ready_o  (fifo_in_ready[g]),
                .in_data_i   (fifo_in[g]),
                .out_valid_o (fifo_out_valid[g]),
                .out_ready_i (fifo_out_ready[g]),
                .out_data_o  (fifo_out[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_sys_i) begin                            // RULE10
        for (int c = 0; c < NCH; c++) begin
            if (ce_i && host_mem_wr[c]) begin
                mem[c][st.ch[c].addr] <= host_i.wdata;
            end else if (ce_i && fifo_out_valid[c] && fifo_out_ready[c]) begin
                mem[c][fifo_out[c].addr] <= fifo_out[c].data;
            end
        end
    end
    assign rdata_o  = st.rdata;
    assign rvalid_o = st.rvalid;
    assign mclk_o   = st.mclk;
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);

    generate
        for (genvar a = 0; a < NCH; a++) begin : g_chk
            unlocked_idle_a: assert property (!st.ch[a].lock |-> st.ch[a].state == CAP_IDLE) // RULE1
                else $error("unlocked channel not idle");
            unlock_clear_a: assert property (ce_i && unlock_wr[a] |=> // RULE8
                    st.ch[a].state == CAP_IDLE && st.ch[a].src == SRC_RESET)
                else $error("unlock did not abort and clear");
            level_stop_a: assert property (ce_i && st.ch[a].state == CAP_RUN && lvl_mode[a] // RULE5
                    && !is_sw(st.ch[a].src) && !(usable[a] && active[a]) && !unlock_wr[a]
                    |=> st.ch[a].state == CAP_DONE)
                else $error("level capture did not stop");
            edge_start_a: assert property (ce_i && st.ch[a].state == CAP_ARMED && !lvl_mode[a] // RULE6
                    && !is_sw(st.ch[a].src) && edge_hit[a] && !host_i.wr
                    |=> st.ch[a].state == CAP_RUN)
                else $error("edge did not start capture");
            cont_hold_a: assert property (ce_i && st.ch[a].state == CAP_RUN && cont_mode[a] // RULE7
                    && !is_sw(st.ch[a].src) && !end_stop[a] && !host_i.wr
                    |=> st.ch[a].state == CAP_RUN)
                else $error("continuous capture ended early");
            addr_step_a: assert property (ce_i && push[a] && fifo_in_ready[a] && !host_i.wr // RULE12
                    && st.ch[a].addr != ADDR_LAST |=> st.ch[a].addr == $past(st.ch[a].addr) + ADDR_ONE)
                else $error("address did not step on stored sample");
            wrap_zero_a: assert property (ce_i && push[a] && fifo_in_ready[a] && st.ch[a].wrap // RULE13
                    && st.ch[a].addr == ADDR_LAST && !host_i.wr |=> st.ch[a].addr == ADDR_FIRST)
                else $error("wrap did not return to zero");
            end_stop_a: assert property (ce_i && end_stop[a] && !host_i.wr // RULE13
                    |=> st.ch[a].state == CAP_DONE ##1 st.ch[a].state != CAP_RUN)
                else $error("capture ran past memory end");
            burst_step_a: assert property (ce_i && host_mem_rd[a] // RULE14
                    |=> rvalid_o && st.ch[a].addr == $past(st.ch[a].addr) + ADDR_ONE)
                else $error("bus access did not advance counter");
            locked_read_a: assert property (ce_i && host_i.rd && st.ch[a].lock // RULE15
                    && reg_hit(host_i, a, OFS_DATA) |=> rvalid_o && rdata_o == '0)
                else $error("memory readable while locked");
            start_c: cover property (st.ch[a].state == CAP_ARMED ##1 st.ch[a].state == CAP_RUN);
            wrap_c: cover property (push[a] && st.ch[a].wrap && st.ch[a].addr == ADDR_LAST);
            sw_c: cover property (sw_hit[a] && st.ch[a].state == CAP_RUN);
            full_c: cover property (push[a] && !fifo_in_ready[a]);
        end
    endgenerate
endmodule : capture_ctrl

`default_nettype wire

/* tb/host_model.sv */
/*
 * Host controller model: one-cycle write and read strobes on the register port.
 * Assumes it shares clk_sys_i with the capture controller.
 */
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input  wire logic                       clk_sys_i,
    output var  capture_pkg::host_req_s     host_o,
    input  wire logic [capture_pkg::DATA_W-1:0] rdata_i,
    input  wire logic                       rvalid_i
);
    import capture_pkg::*;
    initial host_o = '0;
    task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys_i);
        host_o <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys_i);
        host_o.wr    <= 1'b0;
        host_o.wdata <= ~d; // released bus must not keep the last word
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [DATA_W-1:0] d);
        @(posedge clk_sys_i);
        host_o <= '{a, ~host_o.wdata, 1'b0, 1'b1};
        @(posedge clk_sys_i);
        host_o.rd <= 1'b0;
        d = 'x;
        repeat (3) begin
            @(posedge clk_sys_i);
            if (rvalid_i === 1'b1) begin
                d = rdata_i;
                break;
            end
        end
    endtask : rd
endmodule : host_model
`default_nettype wire

/* tb/tb_top.sv */
/*
 * Self-checking bench of capture_ctrl: bus access, lock, trigger modes and sources.
 * Assumes host_model drives the register port.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import capture_pkg::*;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, tick = 1'b0, rvalid, mclk;
    trig_in_s trig = '0;
    logic [NCH-1:0][DATA_W-1:0] adc = '0;
    host_req_s host;
    logic [DATA_W-1:0] rdata, got;
    int mismatches = 0, samples_checked = 0, cycles = 0;
    capture_ctrl capture_ctrl_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
        .host_i(host), .rdata_o(rdata), .rvalid_o(rvalid), .sample_tick_i(tick),
        .adc_i(adc), .trig_i(trig), .mclk_o(mclk));
    host_model host_model_inst (.clk_sys_i(clk_sys_i), .host_o(host), .rdata_i(rdata),
        .rvalid_i(rvalid));
    initial forever #25 clk_sys_i = ~clk_sys_i;
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    always @(posedge clk_sys_i) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            test_done();
        end
    end
    task automatic cmp(input logic [DATA_W-1:0] g, input logic [DATA_W-1:0] e);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp
    task automatic chk(input logic [7:0] a, input logic [DATA_W-1:0] e);
        host_model_inst.rd(a, got);
        cmp(got, e);
    endtask : chk
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            tick <= 1'b1;
            adc[0] <= 24'($urandom);
            adc[1] <= 24'($urandom);
            @(posedge clk_sys_i);
            tick <= 1'b0;
        end
        repeat (3) @(posedge clk_sys_i);
    endtask : ticks
    // software sources toggle capture by writing the source code again
    task automatic trg(input logic c, input logic [7:0] s, input logic v, input logic sw);
        @(posedge clk_sys_i);
        if (s[4] && sw) host_model_inst.wr({c, OFS_SRC}, DATA_W'(s));
        else if (s == SRC_FRONT) trig.front <= v;
        else if (s <= SRC_BP7) trig.bp[3'(s - 8'h01)] <= v;
        else trig.star <= v;
        repeat (3) @(posedge clk_sys_i);
    endtask : trg
    initial begin
        logic [DATA_W-1:0] w [4];
        logic [19:0] a0;
        logic [20:0] sum;
        logic [7:0] s, m;
        logic c, act, wp;
        int k, d, n;
        void'($urandom(32'h5bb17042));
        repeat (20) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int ch = 0; ch < 2; ch++) begin
            c = ch[0];
            a0 = 20'($urandom);
            host_model_inst.wr({c, OFS_ADDR}, DATA_W'(a0));
            for (int j = 0; j < 4; j++) begin
                w[j] = 24'($urandom);
                host_model_inst.wr({c, OFS_DATA}, w[j]);
            end
            chk({c, OFS_ADDR}, DATA_W'(a0 + 20'h4));
            host_model_inst.wr({c, OFS_ADDR}, DATA_W'(a0));
            for (int j = 0; j < 4; j++) chk({c, OFS_DATA}, w[j]);
            host_model_inst.wr({c, OFS_LOCK}, 24'h1);
            chk({c, OFS_LOCK}, 24'h5);
            chk({c, OFS_DATA}, 24'h0);
            host_model_inst.wr({c, OFS_LOCK}, 24'h0);
            chk({c, OFS_ADDR}, DATA_W'(a0 + 20'h4));
            chk({c, OFS_CAPDIV}, 24'h0);
            chk({c, 7'h40}, 24'h0);
        end
        // pulse mode: high one clock in n+1; half mode: toggles every n+1
        for (int j = 0; j < 2; j++) begin
            host_model_inst.wr({j[0], OFS_CLKDIV}, j ? 24'h12 : 24'h2);
            repeat (8) @(posedge clk_sys_i);
            n = 0;
            repeat (30) @(posedge clk_sys_i) n += int'(mclk === 1'b1);
            cmp(DATA_W'(n), j ? 24'hF : 24'hA);
        end
        for (int i = 0; i < 14; i++) begin
            c = i[0] ^ (i > 5);
            m = 8'(i % 6);
            act = ~m[0];
            s = (i == 6) ? 8'h0A : (i == 7) ? SRC_SW_LO : (i == 9) ? SRC_SW_HI
                : (i == 12) ? SRC_ANALOG : 8'($urandom_range(9));
            d = $urandom_range(2);
            k = $urandom_range(4, 1);
            wp = 1'($urandom_range(1));
            // analog with level zero stays active, so it runs until unlock
            n = (s == 8'h0A) ? 0 : (s == SRC_ANALOG) ? 3 * k
                : (s[4] || m < 2) ? k : (m < 4) ? 2 * k : 3 * k;
            n = (n + d) / (d + 1);
            a0 = 20'hFFFFF - 20'($urandom_range(6));
            host_model_inst.wr({c, OFS_ADDR}, DATA_W'(a0));
            host_model_inst.wr({c, OFS_CAPDIV}, DATA_W'(d));
            host_model_inst.wr({c, OFS_SRC}, DATA_W'(s));
            host_model_inst.wr({c, OFS_MODE}, DATA_W'(m));
            host_model_inst.wr({c, OFS_WRAP}, DATA_W'(wp));
            trg(c, s, act, 1'b0);
            trg(c, s, ~act, 1'b0);
            host_model_inst.wr({c, OFS_LOCK}, 24'h1);
            trg(c, s, act, 1'b1);
            ticks(k);
            trg(c, s, ~act, 1'b1);
            ticks(k);
            trg(c, s, act, 1'b0);
            ticks(k);
            host_model_inst.wr({c, OFS_LOCK}, 24'h0);
            sum = 21'(a0) + 21'(n);
            // without wrap the counter parks on the last address
            a0 = (wp || !sum[20]) ? sum[19:0] : ADDR_LAST;
            chk({c, OFS_ADDR}, DATA_W'(a0));
        end
        test_done();
    end
endmodule : tb_top
`default_nettype wire
